// ### src/audio_port_pkg.sv
// shared constants, register map and carrier types of the digital audio serial port
package audio_port_pkg;

  // ----------------------------------------------------------------
  // register map (word indexes, taken from adr[4:2] on the wishbone slave)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 5;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TX = 3'h1;
  localparam logic [2:0] REG_RX = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam int unsigned STAT_NEW_BIT = 0;
  localparam int unsigned STAT_RATE_BAD_BIT = 1;
  localparam int unsigned STAT_CNT_LSB = 16;

  // ----------------------------------------------------------------
  // framing figures
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [5:0] SYNC_ONE = 6'h01;
  localparam logic [5:0] SYNC_TWO = 6'h02;
  localparam logic [5:0] SYNC_NORMAL = 6'h10;
  localparam logic [5:0] FRAME_PCM_ONE = 6'h11;
  localparam logic [5:0] FRAME_PCM_TWO = 6'h12;
  localparam logic [5:0] FRAME_NORMAL = 6'h20;
  localparam logic [5:0] POS_MAX = 6'h3f;
  localparam int unsigned NUM_FRAMES = 3;
  localparam int unsigned FRAME_LEN [NUM_FRAMES] = '{17, 18, 32};
  localparam int unsigned NUM_RATES = 9;
  localparam int unsigned RATE_HZ [NUM_RATES] =
    '{8000, 11025, 12000, 16000, 22050, 24000, 32000, 44100, 48000};
  localparam logic [3:0] RATE_LAST = 4'h8;
  localparam int unsigned LINK_CLK_HZ_DEFAULT = 83_333_333;
  localparam int unsigned CDC_STAGES = 2;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dual;
    logic [3:0] rate;
    logic master;
    logic sync_two;
    logic normal;
    logic enable;
  } port_cfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic bclk;
    logic word_align_line;
    logic rxd;
  } pins_in_t;

  typedef struct packed {
    logic bclk;
    logic bclk_oe;
    logic word_align_line;
    logic word_align_line_oe;
    logic txd;
  } pins_out_t;

endpackage

// ### src/cdc_sync.sv
// plain flip-flop chain that carries levels into another clock domain
`timescale 1ns/1ps
`default_nettype none
module cdc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned STAGES = 2
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [STAGES-1:0][WIDTH-1:0] chain_ff;
  logic [STAGES-1:0][WIDTH-1:0] nxt_chain;

  // no reset: the chain settles within STAGES edges anyway
  always_comb begin
    nxt_chain = {chain_ff[STAGES-2:0], d_i};
  end

  always_ff @(posedge clk_i) begin
    chain_ff <= nxt_chain;
  end

  assign q_o = chain_ff[STAGES-1];
endmodule
`default_nettype wire

// ### src/bclk_divider.sv
// half-period tick generator for the master bit clock
`timescale 1ns/1ps
`default_nettype none
module bclk_divider #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [CNT_W-1:0] half_i,
  output logic tick_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st_ff;
  div_state_t nxt_st;

  // half_i is never zero: the table is clamped to one
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run_i) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= half_i - CNT_W'(1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;
endmodule
`default_nettype wire

// ### src/audio_serial_port.sv
// digital audio serial port: wishbone registers plus link-side framer
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - four lines: data out, data in, two-way bit clock, two-way word align line.
// R2 - control register picks short-sync PCM or long-sync normal framing.
// R3 - PCM: align high for 1 or 2 clocks, low for 16; frame 17/18.
// R4 - normal: align high 16 clocks, low 16 clocks; frame of 32.
// R5 - master drives bit clock and align line; slave receives both.
// R6 - align frequency equals sample rate, one of nine rates 8 to 48 kHz.
// R7 - 16-bit mono words; dual mono, one word per half, only in normal.
// R8 - words are two's complement, passed through unchanged.
// R9 - most significant bit goes first on both data lines.
// R10 - PCM master bit clock is rate times 17 or 18.
// R11 - normal master bit clock is rate times 32.
// R12 - PCM data fills the 16 clocks right after the align pulse.
// R13 - data and align change on falling edge, sampled on rising edge.
module audio_serial_port #(
  parameter int unsigned LINK_CLK_HZ = audio_port_pkg::LINK_CLK_HZ_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire audio_port_pkg::wb_req_t wb_req_i,
  output wire audio_port_pkg::wb_rsp_t wb_rsp_o,
  input wire logic link_clk_i,
  input wire audio_port_pkg::pins_in_t pins_i,
  output wire audio_port_pkg::pins_out_t pins_o
);
  import audio_port_pkg::*;

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    port_cfg_t cfg;
    logic [31:0] tx;
    logic [31:0] tx_shadow;
    logic [31:0] rx;
    logic rx_new;
    logic [15:0] frames;
    logic ack;
    logic [31:0] rdat;
    logic tgl_seen;
  } bus_state_t;

  typedef struct packed {
    pins_in_t pin_s3;
    pins_in_t flt;
    logic bclk;
    logic bclk_prev;
    logic oe;
    logic wa;
    logic wa_last;
    logic txd;
    logic [5:0] pos;
    logic [15:0] sh_l;
    logic [15:0] sh_r;
    logic [31:0] rx_hold;
    logic [31:0] tx_cur;
    logic tgl;
  } link_state_t;

  bus_state_t bs_ff;
  bus_state_t nxt_bs;
  link_state_t ls_ff;
  link_state_t nxt_ls;

  logic rst_l;
  port_cfg_t cfg_l;
  pins_in_t pin_s2;
  logic tgl_s;
  logic tick;
  logic [15:0] half_tbl [NUM_RATES][NUM_FRAMES];
  logic [15:0] half_sel;
  logic [3:0] rate_idx;
  logic [1:0] frame_idx;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // reset and configuration are levels; config should only change while disabled
  cdc_sync #(.WIDTH(1), .STAGES(CDC_STAGES)) u_rst_sync (
    .clk_i(link_clk_i),
    .d_i(rst_i),
    .q_o(rst_l)
  );

  cdc_sync #(.WIDTH($bits(port_cfg_t)), .STAGES(CDC_STAGES)) u_cfg_sync (
    .clk_i(link_clk_i),
    .d_i(bs_ff.cfg),
    .q_o(cfg_l)
  );

  // pins: two stages here, the third lives in the link state
  cdc_sync #(.WIDTH($bits(pins_in_t)), .STAGES(CDC_STAGES)) u_pin_sync (
    .clk_i(link_clk_i),
    .d_i(pins_i),
    .q_o(pin_s2)
  );

  // frame toggle back to the bus side
  cdc_sync #(.WIDTH(1), .STAGES(CDC_STAGES)) u_tgl_sync (
    .clk_i(clk_i),
    .d_i(ls_ff.tgl),
    .q_o(tgl_s)
  );

  // ----------------------------------------------------------------
  // master bit clock divider
  // ----------------------------------------------------------------
  function automatic logic [15:0] half_div(input int unsigned r, input int unsigned f);
    int unsigned q;
    q = LINK_CLK_HZ / (2 * r * f);
    return (q == 0) ? 16'h0001 : 16'(q);
  endfunction

  // half period per rate and frame length, truncated to whole link cycles
  for (genvar g = 0; g < NUM_RATES; g++) begin : g_rate
    for (genvar k = 0; k < NUM_FRAMES; k++) begin : g_frame
      assign half_tbl[g][k] = half_div(RATE_HZ[g], FRAME_LEN[k]); // R6 R10 R11
    end
  end

  // out-of-range rate codes fall back to the highest rate
  assign rate_idx = (cfg_l.rate > RATE_LAST) ? RATE_LAST : cfg_l.rate; // R6
  assign frame_idx = cfg_l.normal ? 2'h2 : (cfg_l.sync_two ? 2'h1 : 2'h0);
  assign half_sel = half_tbl[rate_idx][frame_idx];

  bclk_divider #(.CNT_W(16)) u_div (
    .clk_i(link_clk_i),
    .rst_i(rst_l),
    .run_i(cfg_l.enable & cfg_l.master), // R5
    .half_i(half_sel),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // link-side framer
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] flen;
    logic [5:0] sync_len;
    logic bclk_lvl;
    logic wa_lvl;
    logic rise;
    logic fall;
    logic [5:0] p_new;
    logic [5:0] np;
    logic [15:0] sh_l_n;
    logic [15:0] sh_r_n;
    logic [15:0] word;
    logic [3:0] idx;
    logic in_slot;
    nxt_ls = ls_ff;
    flen = cfg_l.normal ? FRAME_NORMAL : (cfg_l.sync_two ? FRAME_PCM_TWO : FRAME_PCM_ONE); // R3 R4
    sync_len = cfg_l.normal ? SYNC_NORMAL : (cfg_l.sync_two ? SYNC_TWO : SYNC_ONE); // R2
    // third pin stage; a change counts once stages two and three agree
    nxt_ls.pin_s3 = pin_s2;
    for (int b = 0; b < $bits(pins_in_t); b++) begin
      if (pin_s2[b] == ls_ff.pin_s3[b]) begin
        nxt_ls.flt[b] = pin_s2[b];
      end
    end
    // master uses its own clock and align, slave the filtered pins
    bclk_lvl = cfg_l.master ? ls_ff.bclk : ls_ff.flt.bclk; // R5
    wa_lvl = cfg_l.master ? ls_ff.wa : ls_ff.flt.word_align_line; // R5
    nxt_ls.bclk_prev = bclk_lvl;
    rise = bclk_lvl & ~ls_ff.bclk_prev;
    fall = ~bclk_lvl & ls_ff.bclk_prev;
    nxt_ls.oe = cfg_l.enable & cfg_l.master; // R1 R5
    if (cfg_l.master && tick) begin
      nxt_ls.bclk = ~ls_ff.bclk; // R10 R11
    end
    p_new = 6'h00;
    sh_l_n = {ls_ff.sh_l[14:0], ls_ff.flt.rxd}; // R9
    sh_r_n = {ls_ff.sh_r[14:0], ls_ff.flt.rxd}; // R9
    np = (ls_ff.pos >= flen - 6'h01) ? 6'h00 : ls_ff.pos + 6'h01;
    word = 16'h0000;
    idx = 4'h0;
    in_slot = 1'b0;
    if (rise) begin
      // frame starts at the rising edge that first sees the align line high
      nxt_ls.wa_last = wa_lvl; // R13
      if (wa_lvl && !ls_ff.wa_last) begin
        p_new = 6'h00;
      end else begin
        p_new = (ls_ff.pos == POS_MAX) ? POS_MAX : ls_ff.pos + 6'h01;
      end
      nxt_ls.pos = p_new;
      if (cfg_l.normal) begin
        if (p_new < SYNC_NORMAL) begin
          nxt_ls.sh_l = sh_l_n; // R4 R7
        end else if (p_new < FRAME_NORMAL) begin
          nxt_ls.sh_r = sh_r_n; // R7
        end
      end else if (p_new >= sync_len && p_new < sync_len + DATA_BITS) begin
        nxt_ls.sh_l = sh_l_n; // R12
      end
      // last bit of the frame: hand words over and fetch the next tx pair
      if (p_new == flen - 6'h01) begin
        nxt_ls.rx_hold[15:0] = cfg_l.normal ? ls_ff.sh_l : sh_l_n; // R8
        nxt_ls.rx_hold[31:16] = cfg_l.normal ? sh_r_n : 16'h0000;
        nxt_ls.tx_cur = bs_ff.tx_shadow;
        nxt_ls.tgl = ~ls_ff.tgl;
      end
    end
    if (fall) begin
      // drive the bit for the position that the next rising edge samples
      nxt_ls.wa = np < sync_len; // R3 R4 R13
      if (cfg_l.normal) begin
        in_slot = 1'b1;
        idx = np[3:0];
        word = (np >= SYNC_NORMAL && cfg_l.dual) ? ls_ff.tx_cur[31:16] : ls_ff.tx_cur[15:0]; // R7
      end else begin
        in_slot = (np >= sync_len) && (np < sync_len + DATA_BITS); // R12
        idx = 4'(np - sync_len);
        word = ls_ff.tx_cur[15:0];
      end
      nxt_ls.txd = in_slot & word[4'hf - idx]; // R9 R13
    end
    if (!cfg_l.enable) begin
      nxt_ls.bclk = 1'b0;
      nxt_ls.wa = 1'b0;
      nxt_ls.wa_last = 1'b0;
      nxt_ls.txd = 1'b0;
      nxt_ls.pos = 6'h00;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      ls_ff <= '0;
    end else begin
      ls_ff <= nxt_ls;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave and register file
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic req;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic [31:0] cfg_new;
    nxt_bs = bs_ff;
    req = wb_req_i.cyc & wb_req_i.stb;
    cfg_word = {23'h000000, bs_ff.cfg};
    // a call result cannot be part-selected, so merge into a word first
    cfg_new = merge(cfg_word, wb_req_i.dat, wb_req_i.sel);
    stat_word = 32'h0000_0000;
    stat_word[STAT_NEW_BIT] = bs_ff.rx_new;
    stat_word[STAT_RATE_BAD_BIT] = bs_ff.cfg.rate > RATE_LAST;
    stat_word[STAT_CNT_LSB +: 16] = bs_ff.frames;
    // ack one cycle after the request, dropped in the cycle after
    nxt_bs.ack = req & ~bs_ff.ack;
    if (req && !bs_ff.ack) begin
      unique case (wb_req_i.adr[ADR_W-1:2])
        REG_CTRL: nxt_bs.rdat = cfg_word;
        REG_TX: nxt_bs.rdat = bs_ff.tx;
        REG_RX: nxt_bs.rdat = bs_ff.rx;
        REG_STAT: nxt_bs.rdat = stat_word;
        default: nxt_bs.rdat = 32'h0000_0000;
      endcase
    end
    // writes land on the edge where the master sees ack
    if (req && bs_ff.ack && wb_req_i.we) begin
      unique case (wb_req_i.adr[ADR_W-1:2])
        REG_CTRL: nxt_bs.cfg = cfg_new[$bits(port_cfg_t)-1:0]; // R2 R5
        REG_TX: nxt_bs.tx = merge(bs_ff.tx, wb_req_i.dat, wb_req_i.sel); // R8
        REG_STAT: begin
          if (wb_req_i.sel[0] && wb_req_i.dat[STAT_NEW_BIT]) begin
            nxt_bs.rx_new = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // frame event from the link; applied last so a set beats a clear
    nxt_bs.tgl_seen = tgl_s;
    if (tgl_s != bs_ff.tgl_seen) begin
      nxt_bs.rx = ls_ff.rx_hold;
      nxt_bs.tx_shadow = bs_ff.tx;
      nxt_bs.rx_new = 1'b1;
      nxt_bs.frames = bs_ff.frames + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bs_ff <= '{cfg: port_cfg_t'(CTRL_RESET), tx: WORD_RESET, tx_shadow: WORD_RESET,
                 rx: WORD_RESET, rx_new: 1'b0, frames: 16'h0000, ack: 1'b0,
                 rdat: WORD_RESET, tgl_seen: 1'b0};
    end else begin
      bs_ff <= nxt_bs;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_rsp_o = '{ack: bs_ff.ack, dat: bs_ff.rdat};
  assign pins_o = '{bclk: ls_ff.bclk, bclk_oe: ls_ff.oe, word_align_line: ls_ff.wa, // R1
                    word_align_line_oe: ls_ff.oe, txd: ls_ff.txd};
endmodule
`default_nettype wire

// ### testbench/audio_port_chk.sv
// assertion checker bound to the audio serial port
`timescale 1ns/1ps
`default_nettype none
module audio_port_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire audio_port_pkg::wb_req_t wb_req_i,
  input wire audio_port_pkg::wb_rsp_t wb_rsp_o,
  input wire logic link_clk_i,
  input wire audio_port_pkg::pins_in_t pins_i,
  input wire audio_port_pkg::pins_out_t pins_o
);
  import audio_port_pkg::*;
  // --------
  // bit clock rises per align level and per frame
  // --------
  logic b_q, a_q, seen;
  logic [5:0] run, frm;
  wire rise = pins_o.bclk & ~b_q;
  wire chg = pins_o.word_align_line ^ a_q;
  wire up = pins_o.word_align_line & ~a_q;
  // restart when idle, so a half frame at enable is never judged
  always_ff @(posedge link_clk_i) begin
    if (rst_i || !pins_o.bclk_oe) begin
      b_q <= 1'b0;
      a_q <= 1'b0;
      seen <= 1'b0;
      run <= 6'h00;
      frm <= 6'h00;
    end else begin
      b_q <= pins_o.bclk;
      a_q <= pins_o.word_align_line;
      seen <= seen | up;
      run <= chg ? 6'h00 : run + {5'h00, rise};
      frm <= up ? 6'h00 : frm + {5'h00, rise};
    end
  end
  // --------
  // bus and link properties
  // --------
  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) $rose(wb_req_i.stb) |=> wb_rsp_o.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("no ack one cycle after request");
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_rsp_o.ack |=> !wb_rsp_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i) wb_rsp_o.ack |-> $past(wb_req_i.cyc & wb_req_i.stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_oe_pair;
    @(posedge link_clk_i) disable iff (rst_i) pins_o.bclk_oe == pins_o.word_align_line_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("clock and align enables differ");
  property p_txd_fall;
    @(posedge link_clk_i) disable iff (rst_i)
      pins_o.bclk_oe && $changed(pins_o.txd) |-> !pins_o.bclk;
  endproperty
  a_txd_fall: assert property (p_txd_fall)
    else $error("data changed with bit clock high");
  property p_align_fall;
    @(posedge link_clk_i) disable iff (rst_i)
      pins_o.bclk_oe && $changed(pins_o.word_align_line) |-> !pins_o.bclk;
  endproperty
  a_align_fall: assert property (p_align_fall)
    else $error("align changed with bit clock high");
  property p_run;
    @(posedge link_clk_i) disable iff (rst_i)
      pins_o.bclk_oe && seen && chg |-> run inside {1, 2, 16};
  endproperty
  a_run: assert property (p_run)
    else $error("align level held a wrong number of clocks");
  property p_frame;
    @(posedge link_clk_i) disable iff (rst_i)
      pins_o.bclk_oe && seen && up |-> frm inside {17, 18, 32};
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame length wrong");
endmodule
bind audio_serial_port audio_port_chk u_audio_port_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .link_clk_i(link_clk_i), .pins_i(pins_i),
  .pins_o(pins_o));
`default_nettype wire

// ### testbench/codec_model.sv
// behavioural audio codec on the far side of the serial port
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  input wire logic bclk_i,
  input wire logic align_i,
  input wire logic txd_i,
  input wire logic normal_i,
  input wire logic sync_two_i,
  input wire logic [15:0] word_l_i,
  input wire logic [15:0] word_r_i,
  output logic rxd_o,
  output logic [15:0] cap_l_o,
  output logic [15:0] cap_r_o
);
  logic [5:0] pos = 6'h00;
  logic [5:0] nxt;
  logic a_q = 1'b0;
  logic [15:0] sh = 16'h0000;
  wire [5:0] s = normal_i ? 6'h00 : (sync_two_i ? 6'h02 : 6'h01);
  wire [5:0] len = normal_i ? 6'h20 : (sync_two_i ? 6'h12 : 6'h11);
  initial rxd_o = 1'b0;
  // sample on the rise; align rise marks position zero
  always @(posedge bclk_i) begin
    pos = (align_i && !a_q) ? 6'h00 : pos + 6'h01;
    a_q <= align_i;
    sh = {sh[14:0], txd_i};
    if (pos == s + 6'h0f) cap_l_o <= sh;
    if (normal_i && pos == 6'h1f) cap_r_o <= sh;
  end
  // drive on the fall; outside slots the line toggles, never holds
  always @(negedge bclk_i) begin
    nxt = (pos + 6'h01 == len) ? 6'h00 : pos + 6'h01;
    if (normal_i) rxd_o <= (nxt < 6'h10) ? word_l_i[15 - nxt] : word_r_i[31 - nxt];
    else if (nxt >= s && nxt <= s + 6'h0f) rxd_o <= word_l_i[15 - (nxt - s)];
    else rxd_o <= ~rxd_o;
  end
endmodule
`default_nettype wire

// ### testbench/tb_digital_audio_serial_port.sv
// register-level testbench of the audio serial port with a codec model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_digital_audio_serial_port;
  import audio_port_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk_i = 1'b0;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  pins_in_t pin_in;
  pins_out_t pin_out;
  logic rxd, nrm, s2;
  logic [15:0] wl, wr, cap_l, cap_r, f0;
  logic [31:0] q, st;
  logic [8:0] c;
  int errors = 0;
  int checks = 0;
  int ticks = 0;
  // per mode: dual, rate code, two-clock sync, normal framing
  localparam logic [6:0] MODE [4] = '{7'h06, 7'h46, 7'h11, 7'h5d};
  always #2.5 clk_i = ~clk_i;
  initial begin
    #1.7;
    forever #6 link_clk_i = ~link_clk_i;
  end
  // an undriven pin reads low
  assign pin_in = {pin_out.bclk_oe & pin_out.bclk,
    pin_out.word_align_line_oe & pin_out.word_align_line, rxd};
  audio_serial_port #(.LINK_CLK_HZ(24_000_000)) u_audio_serial_port (.clk_i(clk_i),
    .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .link_clk_i(link_clk_i),
    .pins_i(pin_in), .pins_o(pin_out));
  codec_model u_codec_model (.bclk_i(pin_in.bclk), .align_i(pin_in.word_align_line),
    .txd_i(pin_out.txd), .normal_i(nrm), .sync_two_i(s2), .word_l_i(wl), .word_r_i(wr),
    .rxd_o(rxd), .cap_l_o(cap_l), .cap_r_o(cap_r));
  // --------
  // bus access and run control
  // --------
  task automatic wb(input logic w, input logic [2:0] r, input logic [31:0] d,
    output logic [31:0] rd);
    @(posedge clk_i);
    req <= {2'b11, w, 4'hf, r, 2'b00, d};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1) @(posedge clk_i);
    rd = rsp.dat;
    req <= '0;
  endtask
  // waits four frame events; a tx write shows only from the frame after next
  task automatic frames();
    wb(1'b0, REG_STAT, 32'h0, st);
    f0 = st[31:16];
    do wb(1'b0, REG_STAT, 32'h0, st); while (st[31:16] - f0 < 16'h0004);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 90000) begin
      errors++;
      tally_and_finish();
    end
  end
  // --------
  // scenarios
  // --------
  initial begin
    {nrm, s2, wl, wr} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, REG_RX, 32'hffff_ffff, q);
    wb(1'b1, 3'h4, 32'hffff_ffff, q);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, i[2:0], 32'h0, q);
      `CHK(q, WORD_RESET)
    end
    foreach (MODE[i]) begin
      {c[8], c[7:4], c[2], c[1]} = MODE[i];
      c[3] = 1'b1;
      c[0] = 1'b0;
      nrm = c[1];
      s2 = c[2];
      wl = 16'h8001 + 16'(i);
      wr = 16'h4c3a ^ 16'(i);
      wb(1'b1, REG_CTRL, {23'h0, c}, q);
      wb(1'b1, REG_TX, {wr, wl}, q);
      wb(1'b1, REG_CTRL, {23'h0, c | 9'h001}, q);
      wb(1'b0, REG_CTRL, 32'h0, q);
      `CHK(q, {23'h0, c | 9'h001})
      frames();
      `CHK({st[1:0], pin_out.bclk_oe}, 3'b011)
      wb(1'b0, REG_RX, 32'h0, q);
      `CHK(q, {c[1] ? wr : 16'h0, wl})
      `CHK({cap_l, c[1] ? cap_r : 16'h0}, {wl, c[1] ? (c[8] ? wr : wl) : 16'h0})
      wb(1'b1, REG_CTRL, {23'h0, c}, q);
    end
    wb(1'b1, REG_CTRL, 32'h0000_00f9, q);
    frames();
    `CHK(st[1], 1'b1)
    // new-frame flag clears on a write of one; frames are far apart here
    wb(1'b1, REG_STAT, 32'h0000_0001, q);
    wb(1'b0, REG_STAT, 32'h0, st);
    `CHK(st[0], 1'b0)
    wb(1'b1, REG_CTRL, 32'h0000_0008, q);
    repeat (20) @(posedge clk_i);
    `CHK({pin_out.bclk_oe, pin_out.word_align_line, pin_out.txd}, 3'b000)
    // enabled slave with no external clock: pins released, data line quiet
    wb(1'b1, REG_CTRL, 32'h0000_0001, q);
    repeat (20) @(posedge clk_i);
    `CHK({pin_out.bclk_oe, pin_out.word_align_line_oe, pin_out.txd}, 3'b000)
    tally_and_finish();
  end
endmodule
`default_nettype wire
